// ### inc/socm_consts.vh
// Summary of operation
// RL1 - Address in subindex 2 selects the register shown in subindex 1.
// RL2 - 2-byte objects link one address, 4-byte two; count at subindex 0.
// RL3 - Address subindex writable only in Pre-Operational with drive stopped.
// RL4 - Content change accepted only in Pre-Operational with no run active.
// RL5 - Start refused during selection; emergency 6301 sent instead.
// RL6 - Requests or run commands during selection get emergency 6301.
// RL7 - Node reset with changed mapping and run active stops the drive first.
// RL8 - Object 2080 accepts any pair when both addresses are below 0100.
// RL9 - Object 2080 at 0100 or above needs second = first + 1; FFFF allowed.
// RL10 - Object 21F0 accepts non-consecutive address pairs.
// RL11 - One drive register may be linked to only one object at a time.
// RL12 - Addresses 0001, 0002, 0004, 0005 and 0014 are rejected with an error.
// RL13 - Master puts first address in upper 16 bits, second in lower 16 bits.
// RL14 - 15 receive, 16 transmit process-data objects with config and mapping.
// RL15 - Default identifiers 200/300 and 180/280 plus node; others unassigned.
// RL16 - Config and mapping answered at listed indexes with default mappings.
// RL17 - A rejected selection write leaves the previous linkage unchanged.
// RL18 - Address FFFF disables the object; its data reads as zero.
// RL19 - Master clears count, writes entries, then sets count to remap; writes to mapping objects are refused with 0001 here.
`ifndef SOCM_CONSTS_VH
`define SOCM_CONSTS_VH

// Selectable objects and their link slots
`define SOCM_OBJ_IN4 16'h2080
`define SOCM_OBJ_OUT4 16'h21F0
`define SOCM_OBJ_IN2A 16'h2090
`define SOCM_OBJ_IN2B 16'h20A0
`define SOCM_OBJ_OUT2A 16'h21A0
`define SOCM_OBJ_OUT2B 16'h21B0
`define SOCM_OBJ_OUT2C 16'h21C0
`define SOCM_OBJ_OUT2D 16'h21D0
`define SOCM_SLOTS 4'h8
`define SOCM_SUB_COUNT 8'h00
`define SOCM_SUB_DATA 8'h01
`define SOCM_SUB_ADDR 8'h02
`define SOCM_SEL_ENTRIES 32'h0000_0002

// Address limits
`define SOCM_ADDR_NONE 16'hFFFF
`define SOCM_PAIR_NONE 32'hFFFF_FFFF
`define SOCM_ADDR_HIGH 16'h0100
`define SOCM_BAN_A 16'h0001
`define SOCM_BAN_B 16'h0002
`define SOCM_BAN_C 16'h0004
`define SOCM_BAN_D 16'h0005
`define SOCM_BAN_E 16'h0014

// Answer codes
`define SOCM_EMCY_SEL 16'h6301
`define SOCM_ERR_NONE 16'h0000
`define SOCM_ERR_RO 16'h0001
`define SOCM_ERR_BAN 16'h0002
`define SOCM_ERR_PAIR 16'h0003
`define SOCM_ERR_USED 16'h0004
`define SOCM_ERR_NOOBJ 16'h0005

// Process-data objects
`define SOCM_RX_CFG 8'h14
`define SOCM_RX_MAP 8'h16
`define SOCM_TX_CFG 8'h18
`define SOCM_TX_MAP 8'h1A
`define SOCM_RX_CFG_TOP 32'h0000_0002
`define SOCM_TX_CFG_TOP 32'h0000_0005
`define SOCM_COB_RX1 32'h0000_0200
`define SOCM_COB_RX2 32'h0000_0300
`define SOCM_COB_TX1 32'h0000_0180
`define SOCM_COB_TX2 32'h0000_0280
`define SOCM_COB_UNUSED 32'h8000_0000
`define SOCM_MAP_LEN 8'h10

// Network states and commands
`define SOCM_NMT_PREOP 2'h0
`define SOCM_NMT_OPER 2'h1
`define SOCM_NMT_STOPPED 2'h2
`define SOCM_CMD_START 2'h0
`define SOCM_CMD_STOP 2'h1
`define SOCM_CMD_PREOP 2'h2
`define SOCM_CMD_RESET 2'h3

`endif

// ### design/socm_link_mem.v
`timescale 1ns/1ps
`default_nettype none
`include "socm_consts.vh"

module socm_link_mem (
    input wire ref_clk_in,
    input wire sys_rst_in,
    input wire wr_en_in,
    input wire [2:0] wr_slot_in,
    input wire [31:0] wr_data_in,
    input wire [2:0] rd_slot_in,
    output wire [31:0] rd_data_out
);

reg [31:0] link_r [0:7];
reg [31:0] rd_data_r;
integer i;

assign rd_data_out = rd_data_r;

// Every slot starts disabled
always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
        for (i = 0; i < 8; i = i + 1) begin
            link_r[i] <= `SOCM_PAIR_NONE;
        end
        rd_data_r <= `SOCM_PAIR_NONE;
    end else begin
        if (wr_en_in) begin
            link_r[wr_slot_in] <= wr_data_in;
        end
        rd_data_r <= link_r[rd_slot_in];
    end
end

endmodule
`default_nettype wire

// ### design/socm_cfg.v
`timescale 1ns/1ps
`default_nettype none
`include "socm_consts.vh"

module socm_cfg (
    input wire ref_clk_in,
    input wire sys_rst_in,
    input wire [6:0] node_id_in,
    input wire req_valid_in,
    input wire req_write_in,
    input wire [15:0] req_index_in,
    input wire [7:0] req_sub_in,
    input wire [31:0] req_wdata_in,
    output wire req_ready_out,
    output wire rsp_valid_out,
    output wire rsp_err_out,
    output wire [15:0] rsp_code_out,
    output wire [31:0] rsp_rdata_out,
    input wire nmt_valid_in,
    input wire [1:0] nmt_cmd_in,
    output wire [1:0] nmt_state_out,
    input wire run_cmd_in,
    output wire run_cmd_out,
    input wire drive_running_in,
    output wire drive_rd_out,
    output wire [15:0] drive_addr_out,
    input wire drive_ack_in,
    input wire [15:0] drive_data_in,
    output wire drive_stop_out,
    output wire node_reset_out,
    output wire emcy_valid_out,
    output wire [15:0] emcy_code_out,
    output wire sel_busy_out
);

localparam ST_IDLE = 3'd0;
localparam ST_MEM = 3'd1;
localparam ST_SCAN = 3'd2;
localparam ST_DRV1 = 3'd3;
localparam ST_DRV2 = 3'd4;

////////////////////////////////////////////////////////////////////////////////
// Functions

// Slot of a selectable object: {valid, slot}; slots 0 and 1 are 4-byte
function [3:0] socm_slot;
    input [15:0] idx;
    begin
        if (idx == `SOCM_OBJ_IN4) socm_slot = 4'h8;
        else if (idx == `SOCM_OBJ_OUT4) socm_slot = 4'h9;
        else if (idx == `SOCM_OBJ_IN2A) socm_slot = 4'hA;
        else if (idx == `SOCM_OBJ_IN2B) socm_slot = 4'hB;
        else if (idx == `SOCM_OBJ_OUT2A) socm_slot = 4'hC;
        else if (idx == `SOCM_OBJ_OUT2B) socm_slot = 4'hD;
        else if (idx == `SOCM_OBJ_OUT2C) socm_slot = 4'hE;
        else if (idx == `SOCM_OBJ_OUT2D) socm_slot = 4'hF;
        else socm_slot = 4'h0;
    end
endfunction

function socm_banned;
    input [15:0] a;
    begin
        socm_banned = (a == `SOCM_BAN_A) || (a == `SOCM_BAN_B) ||
            (a == `SOCM_BAN_C) || (a == `SOCM_BAN_D) || (a == `SOCM_BAN_E);
    end
endfunction

// Pairing limit of the 4-byte input object
function socm_pair_ok;
    input [31:0] p;
    begin
        if (p[31:16] == `SOCM_ADDR_NONE || p[15:0] == `SOCM_ADDR_NONE)
            socm_pair_ok = 1'b1; // RL9
        else if (p[31:16] < `SOCM_ADDR_HIGH && p[15:0] < `SOCM_ADDR_HIGH)
            socm_pair_ok = 1'b1; // RL8
        else
            socm_pair_ok = (p[15:0] == p[31:16] + 16'h0001); // RL9
    end
endfunction

// True when a live address of the new pair is already in another pair
function socm_overlap;
    input [31:0] n;
    input [31:0] o;
    begin
        socm_overlap = (n[31:16] != `SOCM_ADDR_NONE &&
            (n[31:16] == o[31:16] || n[31:16] == o[15:0])) ||
            (n[15:0] != `SOCM_ADDR_NONE &&
            (n[15:0] == o[31:16] || n[15:0] == o[15:0]));
    end
endfunction

// Default mapping: {valid, count, object 1, object 2}
function [50:0] socm_pdo_map;
    input tx;
    input [7:0] off;
    begin
        case ({tx, off})
        9'h000: socm_pdo_map = {3'b101, 24'h6040_00, 24'h0};
        9'h001: socm_pdo_map = {3'b110, 24'h6040_00, 24'h6060_00};
        9'h005: socm_pdo_map = {3'b110, 24'h6040_00, 24'h6042_00};
        9'h006: socm_pdo_map = {3'b110, 24'h6040_00, 24'h60FE_01};
        9'h007: socm_pdo_map = {3'b110, 24'h6040_00, 24'h6060_00};
        9'h014: socm_pdo_map = {3'b110, 24'h6048_01, 24'h6048_02};
        9'h015: socm_pdo_map = {3'b110, 24'h6049_01, 24'h6049_02};
        9'h016: socm_pdo_map = {3'b110, 24'h604A_01, 24'h604A_02};
        9'h017: socm_pdo_map = {3'b110, 24'h604C_01, 24'h604C_02};
        9'h023: socm_pdo_map = {3'b101, 24'h2000_00, 24'h0};
        9'h024: socm_pdo_map = {3'b101, 24'h2010_00, 24'h0};
        9'h025: socm_pdo_map = {3'b101, 24'h2020_00, 24'h0};
        9'h026: socm_pdo_map = {3'b101, 24'h2030_00, 24'h0};
        9'h027: socm_pdo_map = {3'b101, 24'h2040_01, 24'h0};
        9'h028: socm_pdo_map = {3'b101, 24'h2050_01, 24'h0};
        9'h100: socm_pdo_map = {3'b101, 24'h6041_00, 24'h0};
        9'h101: socm_pdo_map = {3'b110, 24'h6041_00, 24'h6061_00};
        9'h105: socm_pdo_map = {3'b110, 24'h6041_00, 24'h6044_00};
        9'h106: socm_pdo_map = {3'b110, 24'h6041_00, 24'h60FD_00};
        9'h114: socm_pdo_map = {3'b101, 24'h6042_00, 24'h0};
        9'h115: socm_pdo_map = {3'b101, 24'h6043_00, 24'h0};
        9'h116: socm_pdo_map = {3'b110, 24'h6048_01, 24'h6048_02};
        9'h117: socm_pdo_map = {3'b110, 24'h6049_01, 24'h6049_02};
        9'h118: socm_pdo_map = {3'b110, 24'h604A_01, 24'h604A_02};
        9'h119: socm_pdo_map = {3'b110, 24'h604C_01, 24'h604C_02};
        9'h123: socm_pdo_map = {3'b101, 24'h2100_00, 24'h0};
        9'h124: socm_pdo_map = {3'b101, 24'h2110_00, 24'h0};
        9'h125: socm_pdo_map = {3'b101, 24'h2120_00, 24'h0};
        9'h126: socm_pdo_map = {3'b101, 24'h2130_00, 24'h0};
        9'h127: socm_pdo_map = {3'b101, 24'h2140_01, 24'h0};
        9'h128: socm_pdo_map = {3'b101, 24'h2150_01, 24'h0};
        default: socm_pdo_map = 51'h0;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// State

reg [2:0] st_r;
reg [2:0] slot_r;
reg [7:0] sub_r;
reg [31:0] pair_r;
reg [3:0] cnt_r;
reg clash_r;
reg [15:0] val_hi_r;
reg [15:0] drv_addr_r;
reg rsp_valid_r;
reg rsp_err_r;
reg [15:0] rsp_code_r;
reg [31:0] rsp_rdata_r;
reg emcy_r;
reg [1:0] nmt_r;
reg run_r;
reg stop_r;
reg nrst_r;
reg rst_pend_r;
reg changed_r;

wire [31:0] mem_rdata;
wire selecting = (st_r == ST_SCAN);
wire [3:0] req_slot = socm_slot(req_index_in);
wire req_4b = (req_slot[2:0] < 3'd2);
wire [31:0] req_pair = req_4b ? req_wdata_in :
    {`SOCM_ADDR_NONE, req_wdata_in[15:0]};
wire req_tx = (req_index_in[15:8] == `SOCM_TX_CFG) ||
    (req_index_in[15:8] == `SOCM_TX_MAP);
wire req_cfg = (req_index_in[15:8] == `SOCM_RX_CFG) ||
    (req_index_in[15:8] == `SOCM_TX_CFG);
wire req_pdo = req_cfg || (req_index_in[15:8] == `SOCM_RX_MAP) ||
    (req_index_in[15:8] == `SOCM_TX_MAP);
wire [50:0] pdo = socm_pdo_map(req_tx, req_index_in[7:0]); // RL14 RL16
wire [31:0] node_w = {25'h0, node_id_in};
wire [3:0] prev_cnt = cnt_r - 4'h1;
wire hit = (cnt_r != 4'h0) && (prev_cnt[2:0] != slot_r) &&
    socm_overlap(pair_r, mem_rdata); // RL11
wire may_change = (nmt_r == `SOCM_NMT_PREOP) && !drive_running_in; // RL3 RL4
wire drv_hi_live = (drv_addr_r != `SOCM_ADDR_NONE);
wire commit = selecting && (cnt_r == `SOCM_SLOTS) && !clash_r && !hit;
wire [2:0] rd_slot = selecting ? cnt_r[2:0] : req_slot[2:0];
reg [31:0] pdo_data;
reg pdo_ok;

assign req_ready_out = (st_r == ST_IDLE) || selecting;
assign rsp_valid_out = rsp_valid_r;
assign rsp_err_out = rsp_err_r;
assign rsp_code_out = rsp_code_r;
assign rsp_rdata_out = rsp_rdata_r;
assign nmt_state_out = nmt_r;
assign run_cmd_out = run_r;
assign drive_rd_out = ((st_r == ST_DRV1) || (st_r == ST_DRV2)) && drv_hi_live;
assign drive_addr_out = drv_addr_r;
assign drive_stop_out = stop_r;
assign node_reset_out = nrst_r;
assign emcy_valid_out = emcy_r;
assign emcy_code_out = `SOCM_EMCY_SEL;
assign sel_busy_out = selecting;

socm_link_mem u_link (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .wr_en_in(commit), // RL17
    .wr_slot_in(slot_r),
    .wr_data_in(pair_r),
    .rd_slot_in(rd_slot),
    .rd_data_out(mem_rdata)
);

////////////////////////////////////////////////////////////////////////////////
// Process-data object answers

always @* begin
    pdo_ok = pdo[50];
    pdo_data = 32'h0000_0000;
    if (req_cfg) begin // RL15
        if (req_sub_in == `SOCM_SUB_COUNT) begin
            pdo_data = req_tx ? `SOCM_TX_CFG_TOP : `SOCM_RX_CFG_TOP;
        end else if (req_index_in[7:0] == 8'h00) begin
            pdo_data = (req_tx ? `SOCM_COB_TX1 : `SOCM_COB_RX1) + node_w;
        end else if (req_index_in[7:0] == 8'h01) begin
            pdo_data = (req_tx ? `SOCM_COB_TX2 : `SOCM_COB_RX2) + node_w;
        end else begin
            pdo_data = `SOCM_COB_UNUSED; // RL15
        end
    end else if (req_sub_in == 8'h00) begin
        pdo_data = {30'h0, pdo[49:48]};
    end else if (req_sub_in == 8'h01) begin
        pdo_data = {pdo[47:24], `SOCM_MAP_LEN}; // RL16
    end else if (req_sub_in == 8'h02 && pdo[49:48] == 2'd2) begin
        pdo_data = {pdo[23:0], `SOCM_MAP_LEN}; // RL16
    end else begin
        pdo_ok = 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Request sequencer

always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
        st_r <= ST_IDLE;
        slot_r <= 3'h0;
        sub_r <= 8'h00;
        pair_r <= `SOCM_PAIR_NONE;
        cnt_r <= 4'h0;
        clash_r <= 1'b0;
        val_hi_r <= 16'h0000;
        drv_addr_r <= `SOCM_ADDR_NONE;
        rsp_valid_r <= 1'b0;
        rsp_err_r <= 1'b0;
        rsp_code_r <= `SOCM_ERR_NONE;
        rsp_rdata_r <= 32'h0000_0000;
        changed_r <= 1'b0;
    end else begin
        rsp_valid_r <= 1'b0;
        case (st_r)
        ST_IDLE: begin
            slot_r <= req_slot[2:0];
            sub_r <= req_sub_in;
            pair_r <= req_pair;
            rsp_err_r <= 1'b0;
            rsp_code_r <= `SOCM_ERR_NONE;
            rsp_rdata_r <= 32'h0000_0000;
            if (req_valid_in && req_slot[3]) begin
                if (!req_write_in && req_sub_in == `SOCM_SUB_COUNT) begin
                    rsp_valid_r <= 1'b1;
                    rsp_rdata_r <= `SOCM_SEL_ENTRIES; // RL2
                end else if (!req_write_in && (req_sub_in == `SOCM_SUB_DATA ||
                        req_sub_in == `SOCM_SUB_ADDR)) begin
                    st_r <= ST_MEM;
                end else if (req_write_in && req_sub_in == `SOCM_SUB_ADDR) begin
                    rsp_err_r <= 1'b1;
                    if (!may_change) begin
                        rsp_valid_r <= 1'b1;
                        rsp_code_r <= `SOCM_ERR_RO; // RL3 RL4
                    end else if (socm_banned(req_pair[31:16]) ||
                            socm_banned(req_pair[15:0])) begin
                        rsp_valid_r <= 1'b1;
                        rsp_code_r <= `SOCM_ERR_BAN; // RL12
                    end else if (req_slot[2:0] == 3'd0 && // RL10
                            !socm_pair_ok(req_pair)) begin
                        rsp_valid_r <= 1'b1;
                        rsp_code_r <= `SOCM_ERR_PAIR; // RL9
                    end else begin
                        rsp_err_r <= 1'b0;
                        cnt_r <= 4'h0;
                        clash_r <= 1'b0;
                        st_r <= ST_SCAN;
                    end
                end else begin
                    rsp_valid_r <= 1'b1;
                    rsp_err_r <= 1'b1;
                    rsp_code_r <= `SOCM_ERR_RO;
                end
            end else if (req_valid_in) begin
                rsp_valid_r <= 1'b1;
                rsp_err_r <= !(req_pdo && pdo_ok && !req_write_in);
                rsp_code_r <= !req_pdo || !pdo_ok ? `SOCM_ERR_NOOBJ :
                    req_write_in ? `SOCM_ERR_RO : `SOCM_ERR_NONE;
                rsp_rdata_r <= req_write_in ? 32'h0000_0000 : pdo_data;
            end
        end
        ST_MEM: begin
            val_hi_r <= 16'h0000;
            if (sub_r == `SOCM_SUB_ADDR) begin
                rsp_valid_r <= 1'b1;
                rsp_rdata_r <= slot_r < 3'd2 ? mem_rdata :
                    {16'h0000, mem_rdata[15:0]};
                st_r <= ST_IDLE;
            end else begin
                pair_r <= mem_rdata;
                drv_addr_r <= slot_r < 3'd2 ? mem_rdata[31:16] :
                    mem_rdata[15:0]; // RL1
                st_r <= slot_r < 3'd2 ? ST_DRV1 : ST_DRV2;
            end
        end
        ST_SCAN: begin
            cnt_r <= cnt_r + 4'h1;
            clash_r <= clash_r | hit;
            if (cnt_r == `SOCM_SLOTS) begin
                rsp_valid_r <= 1'b1;
                rsp_err_r <= clash_r | hit;
                rsp_code_r <= clash_r | hit ? `SOCM_ERR_USED : `SOCM_ERR_NONE;
                changed_r <= changed_r | !(clash_r | hit);
                st_r <= ST_IDLE;
            end
        end
        ST_DRV1: begin
            if (!drv_hi_live || drive_ack_in) begin
                val_hi_r <= drv_hi_live ? drive_data_in : 16'h0000; // RL18
                drv_addr_r <= pair_r[15:0];
                st_r <= ST_DRV2;
            end
        end
        ST_DRV2: begin
            if (!drv_hi_live || drive_ack_in) begin
                rsp_valid_r <= 1'b1;
                rsp_rdata_r <= {val_hi_r,
                    drv_hi_live ? drive_data_in : 16'h0000}; // RL1 RL18
                st_r <= ST_IDLE;
            end
        end
        default: st_r <= ST_IDLE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Network state, run forwarding and emergencies

always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
        nmt_r <= `SOCM_NMT_PREOP;
        run_r <= 1'b0;
        stop_r <= 1'b0;
        nrst_r <= 1'b0;
        rst_pend_r <= 1'b0;
        emcy_r <= 1'b0;
    end else begin
        emcy_r <= selecting && ((nmt_valid_in &&
            nmt_cmd_in == `SOCM_CMD_START) || run_cmd_in ||
            req_valid_in); // RL5 RL6
        run_r <= run_cmd_in && !selecting; // RL6
        stop_r <= 1'b0;
        nrst_r <= rst_pend_r; // RL7
        rst_pend_r <= 1'b0;
        if (rst_pend_r) begin
            nmt_r <= `SOCM_NMT_PREOP;
        end else if (nmt_valid_in) begin
            case (nmt_cmd_in)
            `SOCM_CMD_START: begin
                if (!selecting) nmt_r <= `SOCM_NMT_OPER; // RL5
            end
            `SOCM_CMD_STOP: nmt_r <= `SOCM_NMT_STOPPED;
            `SOCM_CMD_PREOP: nmt_r <= `SOCM_NMT_PREOP;
            default: begin
                if (changed_r && drive_running_in) begin
                    stop_r <= 1'b1; // RL7
                    rst_pend_r <= 1'b1;
                end else begin
                    nrst_r <= 1'b1;
                    nmt_r <= `SOCM_NMT_PREOP;
                end
            end
            endcase
        end
    end
end

endmodule
`default_nettype wire

// ### bench/socm_cfg_props.sv
`timescale 1ns/1ps
`default_nettype none
module socm_cfg_props (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [15:0] req_index_in,
    input wire logic [7:0] req_sub_in,
    input wire logic [31:0] req_wdata_in,
    input wire logic req_ready_out,
    input wire logic rsp_valid_out,
    input wire logic rsp_err_out,
    input wire logic [15:0] rsp_code_out,
    input wire logic nmt_valid_in,
    input wire logic [1:0] nmt_cmd_in,
    input wire logic [1:0] nmt_state_out,
    input wire logic run_cmd_in,
    input wire logic run_cmd_out,
    input wire logic drive_running_in,
    input wire logic drive_rd_out,
    input wire logic [15:0] drive_addr_out,
    input wire logic drive_ack_in,
    input wire logic drive_stop_out,
    input wire logic node_reset_out,
    input wire logic emcy_valid_out,
    input wire logic [15:0] emcy_code_out,
    input wire logic sel_busy_out
);
default clocking cb @(posedge ref_clk_in); endclocking
default disable iff (sys_rst_in);
// Address write to a 2-byte object outside a scan
wire wr2 = req_valid_in && req_ready_out && !sel_busy_out && req_write_in
    && req_sub_in == 8'h02 && req_index_in == 16'h20A0;
a_emcy_code: assert property (
    emcy_valid_out |-> emcy_code_out == 16'h6301) else $error("bad code");
a_scan_len: assert property (
    $rose(sel_busy_out) |-> ##1 !rsp_valid_out [*8] ##1 rsp_valid_out)
    else $error("scan length wrong");
a_ro_write: assert property (
    wr2 && (nmt_state_out != 2'h0 || drive_running_in) |=> rsp_valid_out
    && rsp_err_out && rsp_code_out == 16'h0001) else $error("ro write");
a_ban_addr: assert property (
    wr2 && nmt_state_out == 2'h0 && !drive_running_in && req_wdata_in[15:0]
    inside {16'h0001, 16'h0002, 16'h0004, 16'h0005, 16'h0014}
    |=> rsp_valid_out && rsp_code_out == 16'h0002) else $error("ban");
a_busy_req: assert property (
    sel_busy_out && req_valid_in |=> emcy_valid_out) else $error("busy req");
a_run_block: assert property (
    sel_busy_out && run_cmd_in |=> emcy_valid_out && !run_cmd_out)
    else $error("run passed during scan");
a_run_pass: assert property (
    !sel_busy_out && run_cmd_in |=> run_cmd_out) else $error("run lost");
a_start_block: assert property (
    sel_busy_out && nmt_valid_in && nmt_cmd_in == 2'h0
    |=> nmt_state_out == 2'h0 && emcy_valid_out) else $error("start taken");
a_stop_first: assert property (
    drive_stop_out |=> node_reset_out) else $error("reset not after stop");
a_rd_hold: assert property (
    drive_rd_out && !drive_ack_in |=> drive_rd_out && $stable(drive_addr_out))
    else $error("drive read dropped");
c_scan: cover property ($rose(sel_busy_out));
c_stop: cover property (drive_stop_out);
c_emcy: cover property (emcy_valid_out);
endmodule
bind socm_cfg socm_cfg_props u_props (.*);
`default_nettype wire

// ### bench/socm_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module socm_drive_model (
    input wire logic clk_in,
    input wire logic rd_in,
    input wire logic [15:0] addr_in,
    input wire logic [3:0] dly_in,
    output logic ack_out,
    output logic [15:0] data_out
);
logic [3:0] cnt_r;
initial begin
    ack_out = 1'b0;
    data_out = 16'h0000;
    cnt_r = 4'h0;
end
// Data lines toggle between answers so a stale value never looks valid
always @(negedge clk_in) begin
    ack_out <= 1'b0;
    data_out <= ~data_out;
    if (rd_in && !ack_out) begin
        if (cnt_r == dly_in) begin
            ack_out <= 1'b1;
            data_out <= ~addr_in;
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
end
endmodule
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "socm_consts.vh"
module tb_top;
logic ref_clk_in, sys_rst_in, req_valid_in, req_write_in, nmt_valid_in;
logic run_cmd_in, drive_running_in;
logic [6:0] node_id_in;
logic [15:0] req_index_in, rsp_c;
logic [7:0] req_sub_in;
logic [31:0] req_wdata_in, rsp_d;
logic [1:0] nmt_cmd_in;
logic [3:0] dly;
wire req_ready_out, rsp_valid_out, rsp_err_out, run_cmd_out, drive_rd_out;
wire drive_ack_in, drive_stop_out, node_reset_out, emcy_valid_out, sel_busy_out;
wire [15:0] rsp_code_out, drive_addr_out, drive_data_in, emcy_code_out;
wire [31:0] rsp_rdata_out;
wire [1:0] nmt_state_out;
int errors, n_tests, k;
socm_cfg u_dut (.*);
socm_drive_model u_drv (.clk_in(ref_clk_in), .rd_in(drive_rd_out),
    .addr_in(drive_addr_out), .dly_in(dly), .ack_out(drive_ack_in),
    .data_out(drive_data_in));
initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
end
////////////////////////////////////////////////////////////////////////////
task chk(input string what, input logic [31:0] exp, input logic [31:0] act);
    n_tests++;
    if (act !== exp) begin
        errors++;
        $display("Error %s expected %h seen %h", what, exp, act);
    end
endtask
task test_done;
    $display("Checks made %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask
task issue(input logic w, input logic [15:0] i, input logic [7:0] s,
    input logic [31:0] d);
    @(negedge ref_clk_in);
    req_valid_in = 1'b1;
    req_write_in = w;
    req_index_in = i;
    req_sub_in = s;
    req_wdata_in = d;
    @(negedge ref_clk_in);
    req_valid_in = 1'b0;
endtask
task wait_rsp;
    k = 0;
    while (rsp_valid_out !== 1'b1 && k < 40) begin
        @(negedge ref_clk_in);
        k++;
    end
    chk("answer", 32'h0000_0001, {31'h0, rsp_valid_out});
    rsp_c = rsp_code_out;
    rsp_d = rsp_rdata_out;
endtask
task rd_chk(input logic [15:0] i, input logic [7:0] s, input logic [31:0] e);
    issue(1'b0, i, s, 32'h0000_0000);
    wait_rsp;
    chk("rdata", e, rsp_d);
endtask
task wr_chk(input logic [15:0] i, input logic [31:0] d, input logic [15:0] c);
    issue(1'b1, i, 8'h02, d);
    wait_rsp;
    chk("code", {16'h0000, c}, {16'h0000, rsp_c});
endtask
task nmt(input logic [1:0] c);
    @(negedge ref_clk_in);
    nmt_valid_in = 1'b1;
    nmt_cmd_in = c;
    @(negedge ref_clk_in);
    nmt_valid_in = 1'b0;
endtask
////////////////////////////////////////////////////////////////////////////
task t_pdo;
    rd_chk(16'h1400, 8'h01, 32'h0000_0205);
    rd_chk(16'h1401, 8'h01, 32'h0000_0305);
    rd_chk(16'h1800, 8'h01, 32'h0000_0185);
    rd_chk(16'h1801, 8'h01, 32'h0000_0285);
    rd_chk(16'h1405, 8'h01, `SOCM_COB_UNUSED);
    rd_chk(16'h1428, 8'h00, `SOCM_RX_CFG_TOP);
    rd_chk(16'h1828, 8'h00, `SOCM_TX_CFG_TOP);
    rd_chk(16'h1600, 8'h01, 32'h6040_0010);
    issue(1'b0, 16'h1429, 8'h00, 32'h0000_0000);
    wait_rsp;
    chk("code", 32'h0000_0005, {16'h0000, rsp_c});
    issue(1'b1, 16'h1600, 8'h00, 32'h0000_0000);
    wait_rsp;
    chk("code", 32'h0000_0001, {16'h0000, rsp_c});
    $display("pdo test done");
endtask
task t_map;
    dly = 4'h3;
    wr_chk(`SOCM_OBJ_IN2A, 32'h0000_0047, 16'h0000);
    rd_chk(`SOCM_OBJ_IN2A, 8'h01, {16'h0000, ~16'h0047});
    rd_chk(`SOCM_OBJ_IN2A, 8'h02, 32'h0000_0047);
    rd_chk(`SOCM_OBJ_IN2A, 8'h00, `SOCM_SEL_ENTRIES);
    wr_chk(`SOCM_OBJ_IN4, 32'h0201_0202, 16'h0000);
    rd_chk(`SOCM_OBJ_IN4, 8'h01, {~16'h0201, ~16'h0202});
    $display("map test done");
endtask
task t_pair;
    logic [15:0] ban [0:4];
    ban = '{16'h0001, 16'h0002, 16'h0004, 16'h0005, 16'h0014};
    dly = 4'h0;
    wr_chk(`SOCM_OBJ_IN4, 32'h0007_0009, 16'h0000);
    wr_chk(`SOCM_OBJ_IN4, 32'h0202_0201, 16'h0003);
    wr_chk(`SOCM_OBJ_IN4, 32'h0201_0203, 16'h0003);
    wr_chk(`SOCM_OBJ_IN4, 32'h0202_0202, 16'h0003);
    rd_chk(`SOCM_OBJ_IN4, 8'h02, 32'h0007_0009);
    wr_chk(`SOCM_OBJ_IN4, 32'h0200_FFFF, 16'h0000);
    wr_chk(`SOCM_OBJ_IN4, 32'hFFFF_0200, 16'h0000);
    rd_chk(`SOCM_OBJ_IN4, 8'h01, {16'h0000, ~16'h0200});
    wr_chk(`SOCM_OBJ_OUT4, 32'h0049_0030, 16'h0000);
    wr_chk(`SOCM_OBJ_OUT2A, 32'h0000_0049, 16'h0004);
    rd_chk(`SOCM_OBJ_OUT2A, 8'h02, 32'h0000_FFFF);
    for (int b = 0; b < 5; b++)
        wr_chk(`SOCM_OBJ_IN2B, {16'h0000, ban[b]}, 16'h0002);
    wr_chk(`SOCM_OBJ_IN2A, 32'h0000_FFFF, 16'h0000);
    rd_chk(`SOCM_OBJ_IN2A, 8'h01, 32'h0000_0000);
    $display("pair test done");
endtask
task t_busy;
    issue(1'b1, `SOCM_OBJ_IN2B, 8'h02, 32'h0000_0050);
    chk("busy", 32'h0000_0001, {31'h0, sel_busy_out});
    run_cmd_in = 1'b1;
    @(negedge ref_clk_in);
    run_cmd_in = 1'b0;
    chk("emcy", 32'h0000_0001, {31'h0, emcy_valid_out});
    chk("run", 32'h0000_0000, {31'h0, run_cmd_out});
    nmt(`SOCM_CMD_START);
    chk("emcy", 32'h0000_0001, {31'h0, emcy_valid_out});
    chk("state", 32'h0000_0000, {30'h0, nmt_state_out});
    issue(1'b0, `SOCM_OBJ_IN2A, 8'h00, 32'h0000_0000);
    chk("emcy", 32'h0000_0001, {31'h0, emcy_valid_out});
    wait_rsp;
    chk("code", 32'h0000_0000, {16'h0000, rsp_c});
    run_cmd_in = 1'b1;
    @(negedge ref_clk_in);
    run_cmd_in = 1'b0;
    chk("run", 32'h0000_0001, {31'h0, run_cmd_out});
    $display("busy test done");
endtask
task t_ro;
    drive_running_in = 1'b1;
    wr_chk(`SOCM_OBJ_IN2B, 32'h0000_0051, 16'h0001);
    drive_running_in = 1'b0;
    nmt(`SOCM_CMD_START);
    chk("state", 32'h0000_0001, {30'h0, nmt_state_out});
    wr_chk(`SOCM_OBJ_IN2B, 32'h0000_0051, 16'h0001);
    rd_chk(`SOCM_OBJ_IN2B, 8'h02, 32'h0000_0050);
    nmt(`SOCM_CMD_STOP);
    chk("state", 32'h0000_0002, {30'h0, nmt_state_out});
    nmt(`SOCM_CMD_PREOP);
    chk("state", 32'h0000_0000, {30'h0, nmt_state_out});
    drive_running_in = 1'b1;
    nmt(`SOCM_CMD_RESET);
    k = 0;
    while (drive_stop_out !== 1'b1 && k < 4) begin
        @(negedge ref_clk_in);
        k++;
    end
    chk("stop", 32'h0000_0001, {31'h0, drive_stop_out});
    @(negedge ref_clk_in);
    chk("reset", 32'h0000_0001, {31'h0, node_reset_out});
    drive_running_in = 1'b0;
    $display("state test done");
endtask
////////////////////////////////////////////////////////////////////////////
initial begin
    {sys_rst_in, run_cmd_in, drive_running_in, req_valid_in, req_write_in} = 5'h10;
    {nmt_valid_in, nmt_cmd_in, req_sub_in, dly} = 15'h0000;
    {req_index_in, req_wdata_in} = 48'h0000_0000_0000;
    node_id_in = 7'h05;
    errors = 0;
    n_tests = 0;
    repeat (5) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    sys_rst_in = 1'b0;
    chk("state", 32'h0000_0000, {30'h0, nmt_state_out});
    rd_chk(`SOCM_OBJ_IN4, 8'h02, `SOCM_PAIR_NONE);
    t_pdo;
    t_map;
    t_pair;
    t_busy;
    t_ro;
    test_done;
end
initial begin
    #50000;
    errors++;
    $display("Error watchdog expected end seen timeout");
    test_done;
end
endmodule
`default_nettype wire
